// *** core/alu_defines.svh ***
// Register map, field positions and fixed byte values of the ALU block.
`ifndef ALU_DEFINES_SVH
`define ALU_DEFINES_SVH
`define APB_AW       8
`define ADDR_CMD     8'h00
`define ADDR_MEM     8'h04
`define ADDR_ACC     8'h08
`define ADDR_FLAGS   8'h0c
`define CMD_OP_LSB   0
`define CMD_OP_MSB   4
`define CMD_BIT_LSB  8
`define CMD_BIT_MSB  10
`define CMD_IMM_LSB  16
`define CMD_IMM_MSB  23
`define FLG_C        0
`define FLG_AC       1
`define FLG_Z        2
`define FLG_OV       3
`define FLG_BUSY     4
`define FLG_SKIP     5
`define ZERO_BYTE    8'h00
`define ONE_BYTE     8'h01
`define ALL_ONES     8'hff
`define ZERO_WORD    32'h0000_0000
`endif

// *** core/alu_pkg.sv ***
// Types shared by the ALU datapath, its sequencer and the bus front end.
package alu_pkg;
    typedef enum logic [4:0] {
        op_rotate_left_thru_carry                  = 5'h00,
        op_rotate_left_thru_carry_to_accumulator   = 5'h01,
        op_rotate_right_plain                      = 5'h02,
        op_rotate_right_to_accumulator             = 5'h03,
        op_rotate_right_thru_carry                 = 5'h04,
        op_rotate_right_thru_carry_to_accumulator  = 5'h05,
        op_subtract_with_borrow                    = 5'h06,
        op_subtract_with_borrow_to_memory          = 5'h07,
        op_subtract                                = 5'h08,
        op_subtract_to_memory                      = 5'h09,
        op_subtract_immediate                      = 5'h0a,
        op_decrement_skip_zero                     = 5'h0b,
        op_decrement_skip_zero_to_accumulator      = 5'h0c,
        op_increment_skip_zero                     = 5'h0d,
        op_increment_skip_zero_to_accumulator      = 5'h0e,
        op_skip_on_bit_set                         = 5'h0f,
        op_set_byte                                = 5'h10,
        op_set_bit                                 = 5'h11,
        op_nibble_exchange                         = 5'h12,
        op_nibble_exchange_to_accumulator          = 5'h13
    } op_e;
    typedef enum logic [1:0] {
        st_idle  = 2'b00,
        st_exec  = 2'b01,
        st_dummy = 2'b10
    } exec_state_e;
    typedef struct packed {
        logic ov;
        logic z;
        logic ac;
        logic c;
    } flags_s;
    typedef struct packed {
        op_e        op;
        logic [2:0] bit_sel;
        logic [7:0] imm;
    } cmd_s;
    typedef struct packed {
        logic [7:0] value;
        logic       to_acc;
        logic       to_mem;
        flags_s     flags;
        logic       skip;
    } result_s;
endpackage

// *** core/alu_compute.sv ***
// Combinational datapath: result, destination, flags and skip of one op.
`timescale 1ns/1ps
`include "alu_defines.svh"
module alu_compute (
    input  wire alu_pkg::cmd_s   i_cmd,   // Latched instruction
    input  wire logic [7:0]      i_mem,   // Data memory byte
    input  wire logic [7:0]      i_acc,   // Accumulator
    input  wire alu_pkg::flags_s i_flags, // Current flags
    output alu_pkg::result_s     o_res    // Outcome of the op
);
    logic [7:0] sub_b;
    logic       sub_cin;
    logic [8:0] sum;
    logic [4:0] half;
    always_comb begin
        sub_b   = (i_cmd.op == alu_pkg::op_subtract_immediate) ?
                  ~i_cmd.imm : ~i_mem;
        sub_cin = 1'b1;
        if (i_cmd.op == alu_pkg::op_subtract_with_borrow ||
            i_cmd.op == alu_pkg::op_subtract_with_borrow_to_memory) begin
            sub_cin = i_flags.c;
        end
        sum  = {1'b0, i_acc} + {1'b0, sub_b} + {8'h00, sub_cin};
        half = {1'b0, i_acc[3:0]} + {1'b0, sub_b[3:0]} + {4'h0, sub_cin};
        // Ops that touch no flag simply hand the current flags back.
        o_res.value  = i_mem;
        o_res.to_acc = 1'b0;
        o_res.to_mem = 1'b0;
        o_res.flags  = i_flags;
        o_res.skip   = 1'b0;
        case (i_cmd.op)
            alu_pkg::op_rotate_left_thru_carry,
            alu_pkg::op_rotate_left_thru_carry_to_accumulator: begin
                o_res.value   = {i_mem[6:0], i_flags.c};
                o_res.flags.c = i_mem[7];
                o_res.to_mem  = (i_cmd.op ==
                                 alu_pkg::op_rotate_left_thru_carry);
                o_res.to_acc  = !o_res.to_mem;
            end
            alu_pkg::op_rotate_right_plain,
            alu_pkg::op_rotate_right_to_accumulator: begin
                o_res.value  = {i_mem[0], i_mem[7:1]};
                o_res.to_mem = (i_cmd.op == alu_pkg::op_rotate_right_plain);
                o_res.to_acc = !o_res.to_mem;
            end
            alu_pkg::op_rotate_right_thru_carry,
            alu_pkg::op_rotate_right_thru_carry_to_accumulator: begin
                o_res.value   = {i_flags.c, i_mem[7:1]};
                o_res.flags.c = i_mem[0];
                o_res.to_mem  = (i_cmd.op ==
                                 alu_pkg::op_rotate_right_thru_carry);
                o_res.to_acc  = !o_res.to_mem;
            end
            alu_pkg::op_subtract_with_borrow,
            alu_pkg::op_subtract_with_borrow_to_memory,
            alu_pkg::op_subtract, alu_pkg::op_subtract_to_memory,
            alu_pkg::op_subtract_immediate: begin
                o_res.value    = sum[7:0];
                o_res.flags.c  = sum[8];
                o_res.flags.ac = half[4];
                o_res.flags.z  = (sum[7:0] == `ZERO_BYTE);
                o_res.flags.ov = (i_acc[7] == sub_b[7]) &&
                                 (sum[7] != i_acc[7]);
                o_res.to_mem   = (i_cmd.op ==
                    alu_pkg::op_subtract_with_borrow_to_memory) ||
                    (i_cmd.op == alu_pkg::op_subtract_to_memory);
                o_res.to_acc   = !o_res.to_mem;
            end
            alu_pkg::op_decrement_skip_zero,
            alu_pkg::op_decrement_skip_zero_to_accumulator: begin
                o_res.value  = i_mem - `ONE_BYTE;
                o_res.skip   = (o_res.value == `ZERO_BYTE);
                o_res.to_mem = (i_cmd.op == alu_pkg::op_decrement_skip_zero);
                o_res.to_acc = !o_res.to_mem;
            end
            alu_pkg::op_increment_skip_zero,
            alu_pkg::op_increment_skip_zero_to_accumulator: begin
                o_res.value  = i_mem + `ONE_BYTE;
                o_res.skip   = (o_res.value == `ZERO_BYTE);
                o_res.to_mem = (i_cmd.op == alu_pkg::op_increment_skip_zero);
                o_res.to_acc = !o_res.to_mem;
            end
            alu_pkg::op_skip_on_bit_set: begin
                o_res.skip = i_mem[i_cmd.bit_sel];
            end
            alu_pkg::op_set_byte: begin
                o_res.value  = `ALL_ONES;
                o_res.to_mem = 1'b1;
            end
            alu_pkg::op_set_bit: begin
                o_res.value  = i_mem | (`ONE_BYTE << i_cmd.bit_sel);
                o_res.to_mem = 1'b1;
            end
            alu_pkg::op_nibble_exchange,
            alu_pkg::op_nibble_exchange_to_accumulator: begin
                o_res.value  = {i_mem[3:0], i_mem[7:4]};
                o_res.to_mem = (i_cmd.op == alu_pkg::op_nibble_exchange);
                o_res.to_acc = !o_res.to_mem;
            end
            default: begin
                o_res.skip = 1'b0;
            end
        endcase
    end
endmodule // alu_compute

// *** core/exec_sequencer.sv ***
// Instruction cycle sequencer: one execute cycle, plus a dummy on skip.
`timescale 1ns/1ps
module exec_sequencer (
    input  wire logic             i_clk,   // Core clock
    input  wire logic             i_rst_n, // Synchronised reset, low
    input  wire logic             i_start, // Instruction accepted
    input  wire logic             i_skip,  // Skip condition of the op
    output alu_pkg::exec_state_e  o_state  // Current cycle type
);
    alu_pkg::exec_state_e next_state;
    always_comb begin
        case (o_state)
            alu_pkg::st_idle:
                next_state = i_start ? alu_pkg::st_exec : alu_pkg::st_idle;
            // The prefetched instruction is dropped by a dummy cycle.
            alu_pkg::st_exec:
                next_state = i_skip ? alu_pkg::st_dummy
                                    : alu_pkg::st_idle;
            alu_pkg::st_dummy:
                next_state = alu_pkg::st_idle;
            default:
                next_state = alu_pkg::st_idle;
        endcase
    end
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_state <= alu_pkg::st_idle;
        end else begin
            o_state <= next_state;
        end
    end
endmodule // exec_sequencer

// *** core/mcu_rotate_subtract_skip_alu.sv ***
// Rotate, subtract, skip and bit-set execution unit with an APB front end.
//
// Functional notes
// - Rotate left through carry back to memory
// - Same rotate into accumulator, memory kept
// - Plain rotate right in memory, flags kept
// - Plain rotate right into accumulator, no flags
// - Rotate right through carry back to memory
// - Same rotate into accumulator, memory kept
// - Subtract with borrow, both destinations, flags
// - Subtract memory, no borrow, both destinations
// - Subtract immediate into accumulator with flags
// - Skip discards prefetch with one dummy cycle
// - Decrement memory, skip on zero result
// - Decrement into accumulator, skip on zero
// - Increment memory, skip on wrap to zero
// - Increment into accumulator, skip on zero
// - Skip when selected memory bit is one
// - Set byte writes all ones
// - Set only the selected bit
// - Swap nibbles of memory byte in place
// - Swapped byte delivered to accumulator
// - Accumulator swap keeps memory and flags
//
// The APB register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "alu_defines.svh"
module mcu_rotate_subtract_skip_alu (
    input  wire logic                 i_clk,        // Core clock
    input  wire logic                 i_rst_n,      // Async reset, low
    input  wire logic [`APB_AW-1:0]   i_paddr,      // APB address
    input  wire logic                 i_psel,       // APB select
    input  wire logic                 i_penable,    // APB access phase
    input  wire logic                 i_pwrite,     // APB write
    input  wire logic [31:0]          i_pwdata,     // APB write data
    input  wire logic [3:0]           i_pstrb,      // APB byte strobes
    output logic      [31:0]          o_prdata,     // APB read data
    output logic                      o_pready,     // APB ready
    output logic                      o_pslverr,    // APB error
    output logic                      o_busy,       // Instruction running
    output logic                      o_dummy_cycle,// Skip dummy cycle
    output logic      [7:0]           o_acc         // Accumulator
);
    ////////////////////////////////////////////////////////////////////////
    logic rst_meta;
    logic rst_n;
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    alu_pkg::cmd_s        cmd;
    alu_pkg::flags_s      flags;
    alu_pkg::result_s     res;
    alu_pkg::exec_state_e state;
    logic [7:0]           mem;
    logic [7:0]           acc_q;
    logic                 last_skip;
    logic                 commit;
    logic                 start;
    logic                 access;
    logic                 wr_fire;
    logic                 rd_valid;
    logic                 addr_hit;
    logic [31:0]          rd_mux;
    logic [31:0]          wdata;

    assign commit        = (state == alu_pkg::st_exec);
    assign o_busy        = (state != alu_pkg::st_idle);
    assign o_dummy_cycle = (state == alu_pkg::st_dummy);
    assign o_acc         = acc_q;

    ////////////////////////////////////////////////////////////////////////
    // Writes stall while an instruction runs so that software never races
    // the datapath commit. Reads wait one extra cycle for registered data.
    assign access   = i_psel && i_penable;
    assign wr_fire  = access && i_pwrite && !o_busy;
    assign start    = wr_fire && (i_paddr == `ADDR_CMD);
    assign o_pready = i_pwrite ? !o_busy : rd_valid;
    assign addr_hit = (i_paddr == `ADDR_CMD) || (i_paddr == `ADDR_MEM) ||
                      (i_paddr == `ADDR_ACC) || (i_paddr == `ADDR_FLAGS);
    assign o_pslverr = access && o_pready && !addr_hit;

    genvar lane;
    generate
        for (lane = 0; lane < 4; lane++) begin : g_lane
            assign wdata[lane*8 +: 8] = i_pstrb[lane] ?
                                        i_pwdata[lane*8 +: 8] : `ZERO_BYTE;
        end
    endgenerate

    always_comb begin
        rd_mux = `ZERO_WORD;
        case (i_paddr)
            `ADDR_CMD: begin
                rd_mux[`CMD_OP_MSB:`CMD_OP_LSB]   = cmd.op;
                rd_mux[`CMD_BIT_MSB:`CMD_BIT_LSB] = cmd.bit_sel;
                rd_mux[`CMD_IMM_MSB:`CMD_IMM_LSB] = cmd.imm;
            end
            `ADDR_MEM:   rd_mux[7:0] = mem;
            `ADDR_ACC:   rd_mux[7:0] = acc_q;
            `ADDR_FLAGS: begin
                rd_mux[`FLG_C]    = flags.c;
                rd_mux[`FLG_AC]   = flags.ac;
                rd_mux[`FLG_Z]    = flags.z;
                rd_mux[`FLG_OV]   = flags.ov;
                rd_mux[`FLG_BUSY] = o_busy;
                rd_mux[`FLG_SKIP] = last_skip;
            end
            default:     rd_mux = `ZERO_WORD;
        endcase
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_valid <= 1'b0;
            o_prdata <= `ZERO_WORD;
        end else begin
            rd_valid <= access && !i_pwrite && !rd_valid && !o_busy;
            if (access && !i_pwrite && !rd_valid && !o_busy) begin
                o_prdata <= rd_mux;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            cmd <= '0;
        end else if (start) begin
            cmd.op      <= alu_pkg::op_e'(wdata[`CMD_OP_MSB:`CMD_OP_LSB]);
            cmd.bit_sel <= wdata[`CMD_BIT_MSB:`CMD_BIT_LSB];
            cmd.imm     <= wdata[`CMD_IMM_MSB:`CMD_IMM_LSB];
        end
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            mem <= `ZERO_BYTE;
        end else if (wr_fire && i_paddr == `ADDR_MEM && i_pstrb[0]) begin
            mem <= wdata[7:0];
        end else if (commit && res.to_mem) begin
            mem <= res.value;
        end
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_q <= `ZERO_BYTE;
        end else if (wr_fire && i_paddr == `ADDR_ACC && i_pstrb[0]) begin
            acc_q <= wdata[7:0];
        end else if (commit && res.to_acc) begin
            acc_q <= res.value;
        end
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            flags <= '0;
        end else if (wr_fire && i_paddr == `ADDR_FLAGS && i_pstrb[0]) begin
            flags.c  <= wdata[`FLG_C];
            flags.ac <= wdata[`FLG_AC];
            flags.z  <= wdata[`FLG_Z];
            flags.ov <= wdata[`FLG_OV];
        end else if (commit) begin
            flags <= res.flags;
        end
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            last_skip <= 1'b0;
        end else if (commit) begin
            last_skip <= res.skip;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    alu_compute u_compute (
        .i_cmd   (cmd),
        .i_mem   (mem),
        .i_acc   (acc_q),
        .i_flags (flags),
        .o_res   (res)
    );

    exec_sequencer u_sequencer (
        .i_clk   (i_clk),
        .i_rst_n (rst_n),
        .i_start (start),
        .i_skip  (res.skip),
        .o_state (state)
    );

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!rst_n);

    sequence s_op(alu_pkg::op_e o);
        commit && cmd.op == o;
    endsequence
    sequence s_skip_tail;
        o_dummy_cycle ##1 !o_busy;
    endsequence

    a_rlc_memory: assert property (
        s_op(alu_pkg::op_rotate_left_thru_carry) |=>
        mem == {$past(mem[6:0]), $past(flags.c)} &&
        flags.c == $past(mem[7]) && flags.z == $past(flags.z))
        else $error("rotate left through carry to memory wrong");
    a_rlc_accum: assert property (
        s_op(alu_pkg::op_rotate_left_thru_carry_to_accumulator) |=>
        acc_q == {$past(mem[6:0]), $past(flags.c)} &&
        mem == $past(mem) && flags.c == $past(mem[7]))
        else $error("rotate left through carry to acc wrong");
    a_rr_memory: assert property (
        s_op(alu_pkg::op_rotate_right_plain) |=>
        mem == {$past(mem[0]), $past(mem[7:1])} && $stable(flags))
        else $error("plain rotate right wrong");
    a_rr_accum: assert property (
        s_op(alu_pkg::op_rotate_right_to_accumulator) |=>
        acc_q == {$past(mem[0]), $past(mem[7:1])} &&
        $stable(mem) && $stable(flags))
        else $error("rotate right to acc wrong");
    a_rrc_memory: assert property (
        s_op(alu_pkg::op_rotate_right_thru_carry) |=>
        mem == {$past(flags.c), $past(mem[7:1])} &&
        flags.c == $past(mem[0]))
        else $error("rotate right through carry wrong");
    a_rrc_accum: assert property (
        s_op(alu_pkg::op_rotate_right_thru_carry_to_accumulator) |=>
        acc_q == {$past(flags.c), $past(mem[7:1])} &&
        flags.c == $past(mem[0]) && $stable(mem))
        else $error("rotate right through carry to acc wrong");
    a_sbc_accum: assert property (
        s_op(alu_pkg::op_subtract_with_borrow) |=>
        acc_q == 8'($past(acc_q) + ~$past(mem) + 8'($past(flags.c))))
        else $error("subtract with borrow result wrong");
    a_sub_memory: assert property (
        s_op(alu_pkg::op_subtract_to_memory) |=>
        mem == 8'($past(acc_q) - $past(mem)) &&
        flags.c == ($past(acc_q) >= $past(mem)))
        else $error("subtract to memory wrong");
    a_sub_immed: assert property (
        s_op(alu_pkg::op_subtract_immediate) |=>
        acc_q == 8'($past(acc_q) - $past(cmd.imm)) &&
        flags.z == (acc_q == `ZERO_BYTE))
        else $error("subtract immediate wrong");
    a_skip_dummy: assert property (
        commit && res.skip |=> s_skip_tail)
        else $error("skip did not give exactly one dummy cycle");
    a_noskip_single: assert property (
        commit && !res.skip |=> !o_busy)
        else $error("non-skipping op took more than one cycle");
    a_dec_skip: assert property (
        s_op(alu_pkg::op_decrement_skip_zero) |=>
        mem == 8'($past(mem) - `ONE_BYTE) && $stable(flags) &&
        o_dummy_cycle == (mem == `ZERO_BYTE))
        else $error("decrement and skip wrong");
    a_inc_accum: assert property (
        s_op(alu_pkg::op_increment_skip_zero_to_accumulator) |=>
        acc_q == 8'($past(mem) + `ONE_BYTE) && $stable(mem) &&
        o_dummy_cycle == (acc_q == `ZERO_BYTE))
        else $error("increment to acc and skip wrong");
    a_bit_skip: assert property (
        s_op(alu_pkg::op_skip_on_bit_set) |=>
        o_dummy_cycle == $past(mem[cmd.bit_sel]) && $stable(flags))
        else $error("bit test skip wrong");
    a_set_byte: assert property (
        s_op(alu_pkg::op_set_byte) |=> mem == `ALL_ONES)
        else $error("set byte did not write all ones");
    a_swap_accum: assert property (
        s_op(alu_pkg::op_nibble_exchange_to_accumulator) |=>
        acc_q == {$past(mem[3:0]), $past(mem[7:4])} &&
        $stable(mem) && $stable(flags))
        else $error("nibble swap to acc wrong");
    a_sub_overflow: assert property (
        s_op(alu_pkg::op_subtract) |=>
        flags.ov == (($past(acc_q[7]) != $past(mem[7])) &&
                     (acc_q[7] != $past(acc_q[7]))) &&
        flags.ac == ($past(acc_q[3:0]) >= $past(mem[3:0])))
        else $error("subtract overflow or half carry wrong");
endmodule // mcu_rotate_subtract_skip_alu

// *** testbench/tb_top.sv ***
// Self-checking APB bench for the rotate, subtract and skip unit.
`timescale 1ns/1ps
`include "alu_defines.svh"
`define CHK(nm, e, g) begin \
    num_checks++; \
    if ((g) !== (e)) begin \
        fails++; \
        $display("Error %s expected %h seen %h", nm, e, g); \
    end \
end
module tb_top;
    logic               i_clk = 1'b0;
    logic               i_rst_n = 1'b0;
    logic [`APB_AW-1:0] i_paddr = 8'h00;
    logic               i_psel = 1'b0;
    logic               i_penable = 1'b0;
    logic               i_pwrite = 1'b0;
    logic [31:0]        i_pwdata = 32'h0;
    logic [3:0]         i_pstrb = 4'hf;
    logic [31:0]        o_prdata;
    logic               o_pready;
    logic               o_pslverr;
    logic               o_busy;
    logic               o_dummy_cycle;
    logic [7:0]         o_acc;
    logic [31:0]        rd;
    logic               er;
    int                 fails = 0;
    int                 num_checks = 0;
    always #5 i_clk = ~i_clk;
    mcu_rotate_subtract_skip_alu uut (.i_clk(i_clk), .i_rst_n(i_rst_n),
        .i_paddr(i_paddr), .i_psel(i_psel), .i_penable(i_penable),
        .i_pwrite(i_pwrite), .i_pwdata(i_pwdata), .i_pstrb(i_pstrb),
        .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
        .o_busy(o_busy), .o_dummy_cycle(o_dummy_cycle), .o_acc(o_acc));
    ////////////////////////////////////////////////////////////
    task automatic report_and_stop;
        $display("Checks %0d, mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        int n;
        @(posedge i_clk);
        i_psel <= 1'b1;
        i_penable <= 1'b0;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_clk);
        i_penable <= 1'b1;
        n = 0;
        do begin
            @(posedge i_clk);
            n++;
        end while (o_pready !== 1'b1 && n < 50);
        r = o_prdata;
        e = o_pslverr;
        if (n >= 50) begin
            fails++;
            report_and_stop();
        end
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask
    // Expected outcome, worked out independently of the design.
    task automatic model(input logic [4:0] op, input logic [2:0] bs,
                         input logic [7:0] x, m, a, input logic [3:0] f,
                         output logic [7:0] em, ea,
                         output logic [3:0] ef, output logic es);
        logic [8:0] s;
        logic [4:0] h;
        logic [7:0] b;
        logic       ci;
        em = m;
        ea = a;
        ef = f;
        es = 1'b0;
        b = (op == 5'h0a) ? x : m;
        ci = (op < 5'h08) ? f[0] : 1'b1;
        s = {1'b0, a} + {1'b0, ~b} + ci;
        h = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + ci;
        case (op)
            5'h00: {ef[0], em} = {m, f[0]};
            5'h01: {ef[0], ea} = {m, f[0]};
            5'h02: em = {m[0], m[7:1]};
            5'h03: ea = {m[0], m[7:1]};
            5'h04: {em, ef[0]} = {f[0], m};
            5'h05: {ea, ef[0]} = {f[0], m};
            5'h06, 5'h08, 5'h0a: ea = s[7:0];
            5'h07, 5'h09: em = s[7:0];
            5'h0b: em = m - 8'h01;
            5'h0c: ea = m - 8'h01;
            5'h0d: em = m + 8'h01;
            5'h0e: ea = m + 8'h01;
            5'h0f: es = m[bs];
            5'h10: em = 8'hff;
            5'h11: em = m | (8'h01 << bs);
            5'h12: em = {m[3:0], m[7:4]};
            5'h13: ea = {m[3:0], m[7:4]};
            default: ;
        endcase
        if (op >= 5'h06 && op <= 5'h0a)
            ef = {(a[7] != b[7]) && (s[7] != a[7]), s[7:0] == 8'h00,
                  h[4], s[8]};
        if (op >= 5'h0b && op <= 5'h0e)
            es = ((op < 5'h0d) ? m == 8'h01 : m == 8'hff);
    endtask
    ////////////////////////////////////////////////////////////
    task automatic run_op(input logic [4:0] op, input logic [2:0] bs,
                          input logic [7:0] x, m, a, input logic [3:0] f);
        logic [7:0] em, ea;
        logic [3:0] ef;
        logic       es;
        int         nb, nd;
        model(op, bs, x, m, a, f, em, ea, ef, es);
        apb(1'b1, `ADDR_MEM, {24'h0, m}, rd, er);
        apb(1'b1, `ADDR_ACC, {24'h0, a}, rd, er);
        apb(1'b1, `ADDR_FLAGS, {28'h0, f}, rd, er);
        apb(1'b1, `ADDR_CMD, {8'h00, x, 5'h00, bs, 3'h0, op}, rd, er);
        nb = 0;
        nd = 0;
        // Busy and dummy are sampled just after each edge, once settled.
        for (int n = 0; n < 8; n++) begin
            #1;
            nb += (o_busy === 1'b1);
            nd += (o_dummy_cycle === 1'b1);
            if (o_busy !== 1'b1) break;
            @(posedge i_clk);
        end
        `CHK("busy cycles", es ? 2 : 1, nb)
        `CHK("dummy cycles", es ? 1 : 0, nd)
        apb(1'b0, `ADDR_MEM, 32'h0, rd, er);
        `CHK("mem", {24'h0, em}, rd)
        apb(1'b0, `ADDR_ACC, 32'h0, rd, er);
        `CHK("acc", {24'h0, ea}, rd)
        `CHK("acc pin", ea, o_acc)
        apb(1'b0, `ADDR_FLAGS, 32'h0, rd, er);
        `CHK("flags", {26'h0, es, 1'b0, ef}, rd)
    endtask
    initial begin
        repeat (12) @(posedge i_clk);
        i_rst_n <= 1'b1;
        repeat (3) @(posedge i_clk);
        apb(1'b0, `ADDR_FLAGS, 32'h0, rd, er);
        `CHK("reset flags", 32'h0, rd)
        apb(1'b0, 8'h10, 32'h0, rd, er);
        `CHK("unmapped err", 1'b1, er)
        `CHK("unmapped data", 32'h0, rd)
        // Three operand sets reach both skip outcomes and both borrows.
        for (int op = 0; op < 20; op++) begin
            run_op(op[4:0], 3'h0, 8'h01, 8'h01, 8'h01, 4'h7);
            run_op(op[4:0], 3'h3, 8'hff, 8'hff, 8'h7f, 4'h8);
            run_op(op[4:0], 3'h6, 8'h01, 8'h96, 8'h80, 4'h0);
        end
        run_op(5'h1f, 3'h1, 8'h55, 8'h3c, 8'h5a, 4'h5);
        report_and_stop();
    end
endmodule // tb_top
